// file: verilog/sra_host.sv
`timescale 1ns/1ns
`include "sra_params.svh"
module sra_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sra_fstate_t;

  sra_fstate_t q;
  sra_fstate_t d;
  logic push;
  logic pop;

  // Pointers wrap at the depth so any depth of two or more works
  always_comb begin
    d = q;
    push = in_valid_i && (q.cnt != (AW+1)'(D));
    pop = out_valid_o && out_ready_i;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready_o = (q.cnt != (AW+1)'(D));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rp];
endmodule : sra_fifo

////////////////////////////////////////////////////////////////////////////////

module sra_host import sra_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  sra_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef struct packed {
    sra_hst_t st;
    logic [4:0] div;
    logic [3:0] bits;
    logic [4:0] left;
    logic ctl;
    logic rdph;
    logic [15:0] sh;
    logic [7:0] rxsh;
    logic [7:0] rx;
    logic rx_valid;
    logic [2:0] so_s;
    logic so;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic sdi_oe;
    logic go;
    logic ack;
    logic [31:0] dat;
    logic [23:0] cfg;
  } sra_hstate_t;

  localparam sra_hstate_t HOST_RST = '{st: H_IDLE, cs_n: 1'b1, default: '0};

  sra_hstate_t q;
  sra_hstate_t d;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [7:0] f_out_data;
  logic req;
  logic wtx;
  logic half_end;
  logic so_nx;
  logic [7:0] rxv;
  logic [7:0] txb;

  sra_fifo #(.W(`SRA_FIFO_W), .D(`SRA_FIFO_D)) i_sra_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .in_data_i(wb_dat_i[7:0]),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready),
    .out_data_o(f_out_data)
  );

  always_comb begin
    d = q;
    f_out_ready = 1'b0;
    // Bus slave: a full queue holds off the ack, so the writer stalls
    req = wb_cyc_i && wb_stb_i && !q.ack;
    wtx = wb_we_i && (wb_adr_i == `SRA_WB_TXD);
    d.ack = req && (!wtx || f_in_ready);
    case (wb_adr_i)
      `SRA_WB_CFG: d.dat = {8'h00, q.cfg};
      `SRA_WB_STAT: d.dat = {28'h0, !f_out_valid, !f_in_ready, q.rx_valid, q.st != H_IDLE};
      `SRA_WB_RXD: d.dat = {24'h0, q.rx};
      default: d.dat = 32'h0;
    endcase
    // Writes and read side effects land on the edge that shows ack
    f_in_valid = q.ack && wb_cyc_i && wb_stb_i && wtx && wb_sel_i[0];
    if (q.ack && wb_we_i && wb_adr_i == `SRA_WB_CFG) begin
      for (int i = 0; i < 3; i++) begin
        if (wb_sel_i[i]) d.cfg[8*i +: 8] = wb_dat_i[8*i +: 8];
      end
    end
    if (q.ack && wb_we_i && wb_adr_i == `SRA_WB_GO && wb_sel_i[0] && wb_dat_i[0]
        && q.st == H_IDLE) begin
      d.go = 1'b1;
    end
    if (q.ack && !wb_we_i && wb_adr_i == `SRA_WB_RXD) d.rx_valid = 1'b0;

    // Link engine; sdo passes three flops before use
    d.so_s = {q.so_s[1:0], link.sdo};
    so_nx = (q.so_s[1] == q.so_s[2]) ? q.so_s[2] : q.so;
    d.so = so_nx;
    half_end = (q.div == 5'(`SRA_HALF_CYC - 1));
    d.div = half_end ? 5'h00 : q.div + 5'h01;
    rxv = q.cfg[`SRA_CFG_CPHA] ? {q.rxsh[6:0], so_nx} : q.rxsh;
    txb = q.cfg[`SRA_CFG_LSB] ? sra_rev8(f_out_data) : f_out_data;
    case (q.st)
      H_IDLE: begin
        d.sclk = q.cfg[`SRA_CFG_CPOL];
        if (q.go) begin
          d.go = 1'b0;
          d.cs_n = 1'b0;
          d.sh = {q.cfg[`SRA_CFG_RW], q.cfg[`SRA_CFG_LSB] ? sra_rev14(q.cfg[13:0])
                  : q.cfg[13:0], q.cfg[`SRA_CFG_BURST]};
          d.ctl = 1'b1;
          d.rdph = 1'b0;
          d.bits = 4'h0;
          d.left = 5'({1'b0, q.cfg[`SRA_CFG_CNT_LO +: 4]}) + 5'h01;
          d.sdi_oe = 1'b1;
          d.sdi = q.cfg[`SRA_CFG_RW];
          d.div = 5'h00;
          d.st = H_LEAD;
        end
      end
      H_LEAD: if (half_end) d.st = H_LO;
      H_LO: if (half_end) begin
        d.sclk = !q.cfg[`SRA_CFG_CPOL];
        if (!q.cfg[`SRA_CFG_CPHA] && q.rdph) d.rxsh = {q.rxsh[6:0], so_nx};
        if (q.cfg[`SRA_CFG_CPHA]) d.sdi = q.sh[15];
        d.st = H_HI;
      end
      H_HI: if (half_end) begin
        d.sclk = q.cfg[`SRA_CFG_CPOL];
        if (q.cfg[`SRA_CFG_CPHA] && q.rdph) d.rxsh = rxv;
        d.sh = {q.sh[14:0], 1'b0};
        if (!q.cfg[`SRA_CFG_CPHA]) d.sdi = q.sh[14];
        d.bits = q.bits + 4'h1;
        d.st = H_LO;
        if (q.bits == (q.ctl ? `SRA_CTRL_LAST : `SRA_BYTE_LAST)) begin
          d.bits = 4'h0;
          d.ctl = 1'b0;
          if (q.rdph) begin
            d.rx = q.cfg[`SRA_CFG_LSB] ? sra_rev8(rxv) : rxv;
            d.rx_valid = 1'b1;
          end
          d.st = (q.left == 5'h00) ? H_TAIL : H_WAIT;
        end
      end
      H_WAIT: begin
        d.div = 5'h00;
        if (!q.cfg[`SRA_CFG_RW]) begin
          // Empty queue parks the clock between bytes
          if (f_out_valid) begin
            f_out_ready = 1'b1;
            d.sh = {txb, 8'h00};
            d.sdi = txb[7];
            d.rdph = 1'b0;
            d.left = q.left - 5'h01;
            d.st = H_LO;
          end
        end else begin
          d.sdi_oe = 1'b0;
          if (!q.rx_valid) begin
            d.rdph = 1'b1;
            d.left = q.left - 5'h01;
            d.st = H_LO;
          end
        end
      end
      H_TAIL: if (half_end) begin
        d.cs_n = 1'b1;
        d.sdi_oe = 1'b0;
        d.st = H_GAP;
      end
      H_GAP: if (half_end) d.st = H_IDLE;
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  assign link.cs_n = q.cs_n;
  assign link.sclk = q.sclk;
  assign link.sdi = q.sdi;
  assign link.sdi_oe = q.sdi_oe;
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
endmodule : sra_host

// file: verilog/sra_params.svh
`ifndef SRA_PARAMS_SVH
`define SRA_PARAMS_SVH
// Contract
// - Device is slave only; master makes clock.
// - Output released except while shifting read data.
// - Order bits 3,4 clear: MSB first, else LSB.
// - Polarity zero: clock idles low, pulses high.
// - Phase zero: capture leading, change trailing.
// - Phase one: capture trailing, change next leading.
// - No clock edges needed while deselected.
// - Frame opens with 16-bit control word.
// - Direction 1 read, burst flag 1 burst.
// - LSB mode reverses the 14 address bits.
// - Single write: control word, one byte, deselect.
// - Single read: control word, device returns byte.
// - Burst write stores byte then increments address.
// - Burst address wraps top to zero.
// - Burst read increments and prefetches next byte.
// - Deselect resets serial logic at any time.
// - Incomplete written byte is discarded.
// - Master releases shared line during read data.

// Device register map
`define SRA_ORDER_ADDR 14'h3FFF
`define SRA_ORDER_RST 8'h00
`define SRA_ORDER_BIT_A 3
`define SRA_ORDER_BIT_B 4
`define SRA_CTRL_LAST 4'hF
`define SRA_BYTE_LAST 4'h7

// Timing
`define SRA_CLK_NS 10
`define SRA_SCLK_HALF_NS 100
`define SRA_HALF_CYC ((`SRA_SCLK_HALF_NS + `SRA_CLK_NS - 1) / `SRA_CLK_NS)

// Host buffer
`define SRA_FIFO_W 8
`define SRA_FIFO_D 16

// Host Wishbone map and configuration fields
`define SRA_WB_CFG 8'h00
`define SRA_WB_GO 8'h04
`define SRA_WB_STAT 8'h08
`define SRA_WB_TXD 8'h0C
`define SRA_WB_RXD 8'h10
`define SRA_CFG_RW 14
`define SRA_CFG_BURST 15
`define SRA_CFG_CPOL 16
`define SRA_CFG_CPHA 17
`define SRA_CFG_LSB 18
`define SRA_CFG_CNT_LO 20
`endif

// file: verilog/sra_pkg.sv
package sra_pkg;

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_CTRL = 5'h02,
    D_WDATA = 5'h04,
    D_RDATA = 5'h08,
    D_DONE = 5'h10
  } sra_dst_t;

  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_LEAD = 7'h02,
    H_LO = 7'h04,
    H_HI = 7'h08,
    H_WAIT = 7'h10,
    H_TAIL = 7'h20,
    H_GAP = 7'h40
  } sra_hst_t;

  function automatic logic [13:0] sra_rev14(input logic [13:0] v);
    logic [13:0] r;
    for (int i = 0; i < 14; i++) r[i] = v[13-i];
    return r;
  endfunction : sra_rev14

  function automatic logic [7:0] sra_rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = v[7-i];
    return r;
  endfunction : sra_rev8

endpackage : sra_pkg

// file: verilog/sra_if.sv
`timescale 1ns/1ns
interface sra_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdi_oe;
  logic sdo;
  logic sdo_oe;

  modport dev (
    input cs_n,
    input sclk,
    input sdi,
    output sdo,
    output sdo_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output sdi,
    output sdi_oe,
    input sdo
  );
endinterface : sra_if

// file: verilog/sra_dev.sv
`timescale 1ns/1ns
`include "sra_params.svh"
module sra_dev import sra_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  sra_if.dev link,
  input wire logic cpol_i,
  input wire logic cpha_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [13:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  output logic lsb_first_o,
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    sra_dst_t st;
    logic [2:0] cs_s;
    logic [2:0] ck_s;
    logic [2:0] di_s;
    logic cs_n;
    logic ck;
    logic di;
    logic [3:0] cnt;
    logic [15:0] sh;
    logic [13:0] addr;
    logic adv;
    logic burst;
    logic [7:0] order;
    logic [7:0] tx;
    logic sdo;
    logic sdo_oe;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sra_dstate_t;

  localparam sra_dstate_t DEV_RST = '{
    st: D_IDLE,
    cs_s: 3'h7,
    cs_n: 1'b1,
    order: `SRA_ORDER_RST,
    default: '0
  };

  sra_dstate_t q;
  sra_dstate_t d;

  logic cs_nx;
  logic ck_nx;
  logic di_nx;
  logic lead;
  logic trail;
  logic cap;
  logic shf;
  logic lsb;
  logic [15:0] word;
  logic [7:0] rx_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.rd = 1'b0;

    // Pin synchronisers, first stage only feeds the second
    d.cs_s = {q.cs_s[1:0], link.cs_n};
    d.ck_s = {q.ck_s[1:0], link.sclk};
    d.di_s = {q.di_s[1:0], link.sdi};

    // A level counts once stages two and three agree
    cs_nx = (q.cs_s[1] == q.cs_s[2]) ? q.cs_s[2] : q.cs_n;
    ck_nx = (q.ck_s[1] == q.ck_s[2]) ? q.ck_s[2] : q.ck;
    di_nx = (q.di_s[1] == q.di_s[2]) ? q.di_s[2] : q.di;
    d.cs_n = cs_nx;
    d.ck = ck_nx;
    d.di = di_nx;

    // Edges are found only from our own clock; a parked clock is harmless
    lead = (ck_nx != q.ck) && (ck_nx != cpol_i);
    trail = (ck_nx != q.ck) && (ck_nx == cpol_i);
    cap = cpha_i ? trail : lead;
    shf = cpha_i ? lead : trail;

    // Either order bit selects LSB first
    lsb = q.order[`SRA_ORDER_BIT_A] | q.order[`SRA_ORDER_BIT_B];

    word = {q.sh[14:0], di_nx};
    rx_byte = lsb ? sra_rev8(word[7:0]) : word[7:0];

    // Burst write address steps one cycle after the strobe
    if (q.adv) begin
      d.addr = q.addr + 14'h0001;
      d.adv = 1'b0;
    end

    // Read data is taken while the read strobe stands
    if (q.rd) begin
      d.tx = (q.addr == `SRA_ORDER_ADDR) ? q.order : reg_rdata_i;
    end

    if (cs_nx) begin
      // Deselect drops any half transfer; an unfinished byte is never written
      d.st = D_IDLE;
      d.cnt = 4'h0;
      d.sdo_oe = 1'b0;
      d.adv = 1'b0;
    end else begin
      case (q.st)
        D_IDLE: begin
          d.st = D_CTRL;
          d.cnt = 4'h0;
        end

        D_CTRL: begin
          if (cap) begin
            d.sh = word;
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == `SRA_CTRL_LAST) begin
              d.cnt = 4'h0;
              d.burst = word[0];
              d.addr = lsb ? sra_rev14(word[14:1]) : word[14:1];
              if (word[15]) begin
                d.st = D_RDATA;
                d.rd = 1'b1;
              end else begin
                d.st = D_WDATA;
              end
            end
          end
        end

        D_WDATA: begin
          if (cap) begin
            d.sh = word;
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == `SRA_BYTE_LAST) begin
              // Byte is complete only at the edge that takes its last bit
              d.cnt = 4'h0;
              d.wdata = rx_byte;
              if (q.addr == `SRA_ORDER_ADDR) begin
                d.order = rx_byte;
              end else begin
                d.wr = 1'b1;
              end
              d.adv = q.burst;
              d.st = q.burst ? D_WDATA : D_DONE;
            end
          end
        end

        D_RDATA: begin
          // Output changes on the edge opposite the capture edge
          if (shf) begin
            d.sdo_oe = 1'b1;
            d.sdo = lsb ? q.tx[0] : q.tx[7];
            d.tx = lsb ? {1'b0, q.tx[7:1]} : {q.tx[6:0], 1'b0};
          end
          if (cap) begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == `SRA_BYTE_LAST) begin
              d.cnt = 4'h0;
              if (q.burst) begin
                // Prefetch gives half a clock of slack before the next bit
                d.addr = q.addr + 14'h0001;
                d.rd = 1'b1;
              end else begin
                d.st = D_DONE;
              end
            end
          end
        end

        D_DONE: begin
          // Surplus clocks after a single access are ignored
          d.sdo_oe = 1'b0;
        end

        default: begin
          d.st = D_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Everything leaves straight from flops except lsb_first_o and busy_o, which are decoded from flops
  assign link.sdo = q.sdo;
  assign link.sdo_oe = q.sdo_oe;
  assign reg_wr_o = q.wr;
  assign reg_rd_o = q.rd;
  assign reg_addr_o = q.addr;
  assign reg_wdata_o = q.wdata;
  assign lsb_first_o = q.order[`SRA_ORDER_BIT_A] | q.order[`SRA_ORDER_BIT_B];
  assign busy_o = (q.st != D_IDLE);

endmodule : sra_dev

// file: testbench/sra_chk.sv
`timescale 1ns/1ns
module sra_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdi_oe,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic sclk_q;
  logic [7:0] since_q;

  // Cycles since the last serial clock change, saturating so it never wraps
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk;
    if (rst_i || sclk != sclk_q) since_q <= 8'h00;
    else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame opening: select falls, clock stays put for the lead half
  sequence sel_s;
    $fell(cs_n);
  endsequence
  sequence lead_s;
    $stable(sclk) [*8];
  endsequence

  lead_hold_a: assert property (sel_s |-> lead_s)
    else $error("serial clock moved in lead half");
  half_per_a: assert property (!cs_n && $changed(sclk) |=> $stable(sclk) [*8])
    else $error("serial clock half period too short");
  tail_hold_a: assert property ($rose(cs_n) |-> since_q >= 8'h08)
    else $error("deselect too soon after last clock edge");
  duplex_a: assert property (!(sdi_oe && sdo_oe))
    else $error("both ends drive the data line");
  sdi_sel_a: assert property (sdi_oe |-> !cs_n)
    else $error("host drives data while deselected");
  idle_rel_a: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("device drives data while idle");
  desel_rel_a: assert property ($rose(cs_n) |-> ##[0:6] !sdo_oe)
    else $error("device kept driving after deselect");
  // Read data may only move a few cycles after a clock edge, never mid-half
  sdo_edge_a: assert property (sdo_oe && $stable(sdo_oe) && $changed(sdo)
    |-> since_q inside {[8'h01:8'h06]})
    else $error("read data changed away from shift edge");
endmodule : sra_chk

// file: testbench/tb_serial_register_access_slave.sv
`timescale 1ns/1ns
`include "sra_params.svh"
module tb_serial_register_access_slave;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, wr, lsb, sc_q, dbusy;
  logic [13:0] ra;
  logic [7:0] wd;
  logic [7:0] mem [0:16383];
  logic [23:0] sh;
  int error_cnt = 0;
  int compares = 0;

  sra_if lnk ();
  always #5 clk_i = ~clk_i;

  sra_host i_sra_host (.clk_i(clk_i), .rst_i(rst_i), .link(lnk.host), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  sra_dev i_sra_dev (.clk_i(clk_i), .rst_i(rst_i), .link(lnk.dev), .cpol_i(cpol),
    .cpha_i(cpha), .reg_wr_o(wr), .reg_rd_o(), .reg_addr_o(ra), .reg_wdata_o(wd),
    .reg_rdata_i(mem[ra]), .lsb_first_o(lsb), .busy_o(dbusy));
  sra_chk i_sra_chk (.clk_i(clk_i), .rst_i(rst_i), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
    .sdi(lnk.sdi), .sdi_oe(lnk.sdi_oe), .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // Register file behind the device; preset so reads have known content
  initial for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'hA5;
  always @(posedge clk_i) if (wr) mem[ra] <= wd;

  // Wire monitor: shift whichever end drives, on the capture edge of the mode
  always @(posedge clk_i) begin
    sc_q <= lnk.sclk;
    if (!lnk.cs_n && lnk.sclk != sc_q && (lnk.sclk ^ cpol ^ cpha))
      sh <= {sh[22:0], lnk.sdo_oe ? lnk.sdo : lnk.sdi};
  end

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // Classic single Wishbone cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 100) error_cnt++;
  endtask : wb

  function automatic logic [31:0] cw(input logic [13:0] a, input logic r, input logic b,
    input logic l, input logic [3:0] n1);
    return {8'h00, n1, 1'b0, l, cpha, cpol, b, r, a};
  endfunction : cw

  task go(input logic [31:0] c);
    wb(1'b1, `SRA_WB_CFG, c);
    wb(1'b1, `SRA_WB_GO, 32'h1);
  endtask : go

  task idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, `SRA_WB_STAT, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 2000);
    if (n == 2000) error_cnt++;
  endtask : idle

  // Wait for a received byte, then pop it; delay here stalls the host clock
  task get(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      wb(1'b0, `SRA_WB_STAT, 32'h0);
      n++;
    end while (q[1] !== 1'b1 && n < 2000);
    if (n == 2000) error_cnt++;
    wb(1'b0, `SRA_WB_RXD, 32'h0);
    chk(32'(q[7:0]), 32'(e));
  endtask : get

  task mode(input logic [1:0] m);
    @(posedge clk_i);
    cpol <= m[0];
    cpha <= m[1];
    @(posedge clk_i);
  endtask : mode

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    wb(1'b0, `SRA_WB_STAT, 32'h0);
    chk(q, 32'h8);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk(32'(lsb), 32'h0);
    chk(32'(lnk.sdo_oe), 32'h0);
    chk(32'(dbusy), 32'h0);
  endtask : t_reset

  // Single write then single read in every polarity and phase
  task t_single;
    logic [13:0] a;
    logic [7:0] d;
    for (int m = 0; m < 4; m++) begin
      mode(m[1:0]);
      a = 14'h0020 + 14'(m);
      d = 8'h3C ^ 8'(m);
      wb(1'b1, `SRA_WB_TXD, 32'(d));
      go(cw(a, 1'b0, 1'b0, 1'b0, 4'h0));
      idle;
      chk(32'(mem[a]), 32'(d));
      chk(32'(sh), {8'h00, 1'b0, a, 1'b0, d});
      chk(32'(sh[7:0]), 32'(d));
      chk(32'(dbusy), 32'h0);
      a = 14'h0100 + 14'(m);
      go(cw(a, 1'b1, 1'b0, 1'b0, 4'h0));
      get(8'(m) ^ 8'hA5);
      idle;
      chk(32'(sh), {8'h00, 1'b1, a, 1'b0, 8'(m) ^ 8'hA5});
    end
    mode(2'b00);
  endtask : t_single

  // Fill the buffer to full, then one sixteen-byte burst drains it
  task t_burst_wr;
    for (int i = 0; i < 16; i++) wb(1'b1, `SRA_WB_TXD, 32'h80 + 32'(i));
    wb(1'b0, `SRA_WB_STAT, 32'h0);
    chk(32'(q[3:2]), 32'h1);
    go(cw(14'h0010, 1'b0, 1'b1, 1'b0, 4'hF));
    idle;
    for (int i = 0; i < 16; i++) chk(32'(mem[16 + i]), 32'h80 + 32'(i));
    chk(32'(q[3:2]), 32'h2);
  endtask : t_burst_wr

  task t_burst_rd;
    go(cw(14'h3FFE, 1'b1, 1'b1, 1'b0, 4'h2));
    get(8'h5B);
    get(8'h00);
    get(8'hA5);
    idle;
  endtask : t_burst_rd

  // Order register: bit 3 or bit 4 selects LSB first, both clear MSB first
  task t_order;
    logic [7:0] ov [0:2];
    logic l;
    ov = '{8'h08, 8'h10, 8'h00};
    l = 1'b0;
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, `SRA_WB_TXD, 32'(ov[i]));
      go(cw(14'h3FFF, 1'b0, 1'b0, l, 4'h0));
      idle;
      l = (ov[i] != 8'h00);
      chk(32'(lsb), 32'(l));
      if (i == 0) begin
        wb(1'b1, `SRA_WB_TXD, 32'h5A);
        go(cw(14'h1234, 1'b0, 1'b0, 1'b1, 4'h0));
        idle;
        chk(32'(mem[14'h1234]), 32'h5A);
        chk(32'(sh), {8'h00, 1'b0, 14'h0B12, 1'b0, 8'h5A});
        go(cw(14'h1234, 1'b1, 1'b0, 1'b1, 4'h0));
        get(8'h5A);
        idle;
      end
    end
  endtask : t_order

  ////////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset;
    t_single;
    t_burst_wr;
    t_burst_rd;
    t_order;
    test_done;
  end

  // Watchdog: all frames together need well under this span
  initial begin
    #800000;
    error_cnt++;
    test_done;
  end
endmodule : tb_serial_register_access_slave
